//--- tcw_pkg.sv
// Notes on behaviour
// - mode bit zero selects normal channel switching
// - bits 13..9 name the source stream
// - bits 8..1 name the source channel
// - enable low: no translation, high word ignored
// - enable high: translate using the high word
// - delay select low: constant-delay data memory
// - delay select high: variable-delay data memory
// - mode bit one: special per-channel output mode
// - bits 10..3 are the message byte
// - special mode: enable translates message byte only
// - space line high plus select picks word
// - equal input and output law: no translation
package tcw_pkg;
   // ----------------------------------------
   // low word field positions
   // ----------------------------------------
   localparam int MODE_BIT = 0;
   localparam int LAW_EN_BIT = 15;
   localparam int DELAY_SEL_BIT = 14;
   localparam int STREAM_HI = 13;
   localparam int STREAM_LO = 9;
   localparam int CHAN_HI = 8;
   localparam int CHAN_LO = 1;
   localparam int CODE_HI_BIT = 2;
   localparam int CODE_LO_BIT = 1;
   localparam int MESSAGE_HI = 10;
   localparam int MESSAGE_LO = 3;
   // ----------------------------------------
   // high word field positions
   // ----------------------------------------
   localparam int VD_BIT = 4;
   localparam int IN_LAW_HI = 3;
   localparam int IN_LAW_LO = 2;
   localparam int OUT_LAW_HI = 1;
   localparam int OUT_LAW_LO = 0;
   localparam int HIGH_W = 5;
   // ----------------------------------------
   // host address layout and word select codes
   // ----------------------------------------
   localparam int SPACE_BIT = 13;
   localparam int ADDR_W = 14;
   localparam logic [1:0] SEL_LOW = 2'h1;
   localparam logic [1:0] SEL_HIGH = 2'h2;
   localparam logic [15:0] LOW_RESET = 16'h0000;
   localparam logic [HIGH_W-1:0] HIGH_RESET = 5'h00;
   localparam logic [1:0] CODE_TRISTATE = 2'h0;
   localparam logic [1:0] CODE_MESSAGE = 2'h1;
   localparam logic [1:0] CODE_BER = 2'h2;
   // ----------------------------------------
   // per-channel output mode, one-hot
   // ----------------------------------------
   typedef enum logic [3:0] {
      TCW_SWITCH = 4'h1,
      TCW_TRISTATE = 4'h2,
      TCW_MESSAGE = 4'h4,
      TCW_BER = 4'h8
   } tcw_mode_t;
endpackage

//--- tcw_decode_if.sv
`timescale 1ns/1ps
interface tcw_decode_if;
   logic [15:0] low_word;
   logic [4:0] high_word;
   tcw_pkg::tcw_mode_t mode;
   logic [4:0] src_stream;
   logic [7:0] src_channel;
   logic variable_delay;
   logic convert;
   logic [7:0] message_byte;
   logic reserved_code;
   modport dec (input low_word, high_word, output mode, src_stream, src_channel,
      variable_delay, convert, message_byte, reserved_code);
   modport user (output low_word, high_word, input mode, src_stream, src_channel,
      variable_delay, convert, message_byte, reserved_code);
endinterface

//--- tcw_word_decode.sv
`timescale 1ns/1ps
module tcw_word_decode (
   // connection words in, decoded fields out
   tcw_decode_if.dec d
);
   logic [1:0] code;
   logic [1:0] in_law;
   logic [1:0] out_law;
   logic law_en;

   // ----------------------------------------
   // field extraction
   // ----------------------------------------
   assign code = {d.low_word[tcw_pkg::CODE_HI_BIT], d.low_word[tcw_pkg::CODE_LO_BIT]};
   assign in_law = d.high_word[tcw_pkg::IN_LAW_HI:tcw_pkg::IN_LAW_LO];
   assign out_law = d.high_word[tcw_pkg::OUT_LAW_HI:tcw_pkg::OUT_LAW_LO];
   assign law_en = d.low_word[tcw_pkg::LAW_EN_BIT];
   assign d.src_stream = d.low_word[tcw_pkg::STREAM_HI:tcw_pkg::STREAM_LO];
   assign d.src_channel = d.low_word[tcw_pkg::CHAN_HI:tcw_pkg::CHAN_LO];
   assign d.reserved_code = d.low_word[tcw_pkg::MODE_BIT] & (&code);

   // mode, delay and translation decisions
   always_comb begin
      d.mode = tcw_pkg::TCW_SWITCH;
      d.variable_delay = 1'b0;
      d.message_byte = 8'h00;
      // translation needs enable and differing laws; high word ignored otherwise
      d.convert = law_en && (in_law != out_law);
      if (!d.low_word[tcw_pkg::MODE_BIT]) begin
         d.variable_delay = d.low_word[tcw_pkg::DELAY_SEL_BIT];
      end else begin
         case (code)
            tcw_pkg::CODE_MESSAGE: begin
               d.mode = tcw_pkg::TCW_MESSAGE;
               d.message_byte = d.low_word[tcw_pkg::MESSAGE_HI:tcw_pkg::MESSAGE_LO];
            end
            tcw_pkg::CODE_BER: begin
               d.mode = tcw_pkg::TCW_BER;
            end
            default: begin
               // reserved code falls back to tristate: the safest output
               d.mode = tcw_pkg::TCW_TRISTATE;
            end
         endcase
         // only a message byte can be translated
         d.convert = d.convert && (d.mode == tcw_pkg::TCW_MESSAGE);
      end
   end
endmodule

//--- tcw_connection_decode.sv
`timescale 1ns/1ps
module tcw_connection_decode #(
   parameter int STREAMS = 32,
   parameter int CHANNELS = 256
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // host port
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [13:0] host_addr,
   input wire logic [15:0] host_wdata,
   input wire logic [1:0] word_select,
   output logic [15:0] host_rdata,
   output logic host_rd_valid,
   // tdm output side request
   input wire logic fetch,
   input wire logic [4:0] out_stream,
   input wire logic [7:0] out_channel,
   // decoded channel settings
   output logic dec_valid,
   output tcw_pkg::tcw_mode_t dec_mode,
   output logic [4:0] dec_src_stream,
   output logic [7:0] dec_src_channel,
   output logic dec_variable_delay,
   output logic dec_convert,
   output logic [1:0] dec_input_law,
   output logic [1:0] dec_output_law,
   output logic dec_vd_class,
   output logic [7:0] dec_message_byte,
   output logic dec_reserved_code
);
   // the index keeps a full eight-bit channel field, so short streams leave holes
   localparam int DEPTH = STREAMS * 256;
   localparam int IDX_W = 13;

   // the packed stream and channel index cannot serve larger counts
   if (STREAMS < 1 || STREAMS > 32 || CHANNELS < 1 || CHANNELS > 256) begin : g_bad_size
      $error("stream or channel count out of range");
   end

   // ----------------------------------------
   // connection word storage
   // ----------------------------------------
   logic [15:0] low_mem [DEPTH];
   logic [tcw_pkg::HIGH_W-1:0] high_mem [DEPTH];
   logic [IDX_W-1:0] host_idx;
   logic [IDX_W-1:0] out_idx;
   logic host_hit;
   logic low_we;
   logic high_we;

   // host address: stream on upper bits, channel on lower
   assign host_idx = host_addr[IDX_W-1:0];
   assign out_idx = {out_stream, out_channel};
   assign host_hit = host_addr[tcw_pkg::SPACE_BIT]
      && (32'(host_addr[12:8]) < STREAMS) && (32'(host_addr[7:0]) < CHANNELS);
   assign low_we = host_wr && host_hit && (word_select == tcw_pkg::SEL_LOW);
   assign high_we = host_wr && host_hit && (word_select == tcw_pkg::SEL_HIGH);

   // memory writes; arrays carry no reset, so software must load them
   always_ff @(posedge core_clk) begin
      if (low_we) begin
         low_mem[host_idx] <= host_wdata;
      end
      if (high_we) begin
         high_mem[host_idx] <= host_wdata[tcw_pkg::HIGH_W-1:0];
      end
   end

   // ----------------------------------------
   // host read path
   // ----------------------------------------
   logic [15:0] rdata_d, rdata_q;
   logic rvalid_d, rvalid_q;

   // unmapped or other selects read as zero
   always_comb begin
      rdata_d = rdata_q;
      rvalid_d = host_rd;
      if (host_rd) begin
         rdata_d = 16'h0000;
         if (host_hit && word_select == tcw_pkg::SEL_LOW) begin
            rdata_d = low_mem[host_idx];
         end else if (host_hit && word_select == tcw_pkg::SEL_HIGH) begin
            rdata_d = {11'h000, high_mem[host_idx]};
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 16'h0000;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign host_rdata = rdata_q;
   assign host_rd_valid = rvalid_q;

   // ----------------------------------------
   // fetch stage: words read, then decoded
   // ----------------------------------------
   logic [15:0] low_d, low_q;
   logic [tcw_pkg::HIGH_W-1:0] high_d, high_q;
   logic fvalid_d, fvalid_q;

   always_comb begin
      low_d = low_q;
      high_d = high_q;
      fvalid_d = fetch;
      if (fetch) begin
         low_d = low_mem[out_idx];
         high_d = high_mem[out_idx];
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         low_q <= tcw_pkg::LOW_RESET;
         high_q <= tcw_pkg::HIGH_RESET;
         fvalid_q <= 1'b0;
      end else begin
         low_q <= low_d;
         high_q <= high_d;
         fvalid_q <= fvalid_d;
      end
   end

   tcw_decode_if dif ();
   assign dif.low_word = low_q;
   assign dif.high_word = high_q;

   tcw_word_decode u_dec (
      .d(dif.dec)
   );

   // ----------------------------------------
   // registered decoded outputs
   // ----------------------------------------
   tcw_pkg::tcw_mode_t mode_d, mode_q;
   logic [4:0] stream_d, stream_q;
   logic [7:0] chan_d, chan_q;
   logic vdel_d, vdel_q;
   logic conv_d, conv_q;
   logic vd_d, vd_q;
   logic res_d, res_q;
   logic dvalid_d, dvalid_q;
   logic [1:0] in_law_d, in_law_q;
   logic [1:0] out_law_d, out_law_q;
   logic [7:0] message_d, message_q;

   // settings hold between fetches, so a late sampler still sees the last channel
   always_comb begin
      dvalid_d = fvalid_q;
      mode_d = mode_q;
      stream_d = stream_q;
      chan_d = chan_q;
      vdel_d = vdel_q;
      conv_d = conv_q;
      in_law_d = in_law_q;
      out_law_d = out_law_q;
      vd_d = vd_q;
      message_d = message_q;
      res_d = res_q;
      if (fvalid_q) begin
         mode_d = dif.mode;
         stream_d = dif.src_stream;
         chan_d = dif.src_channel;
         vdel_d = dif.variable_delay;
         conv_d = dif.convert;
         in_law_d = high_q[tcw_pkg::IN_LAW_HI:tcw_pkg::IN_LAW_LO];
         out_law_d = high_q[tcw_pkg::OUT_LAW_HI:tcw_pkg::OUT_LAW_LO];
         vd_d = high_q[tcw_pkg::VD_BIT];
         message_d = dif.message_byte;
         res_d = dif.reserved_code;
      end
   end

   // reset shows the idle settings of a switched channel
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dvalid_q <= 1'b0;
         mode_q <= tcw_pkg::TCW_SWITCH;
         stream_q <= 5'h00;
         chan_q <= 8'h00;
         vdel_q <= 1'b0;
         conv_q <= 1'b0;
         in_law_q <= 2'h0;
         out_law_q <= 2'h0;
         vd_q <= 1'b0;
         message_q <= 8'h00;
         res_q <= 1'b0;
      end else begin
         dvalid_q <= dvalid_d;
         mode_q <= mode_d;
         stream_q <= stream_d;
         chan_q <= chan_d;
         vdel_q <= vdel_d;
         conv_q <= conv_d;
         in_law_q <= in_law_d;
         out_law_q <= out_law_d;
         vd_q <= vd_d;
         message_q <= message_d;
         res_q <= res_d;
      end
   end

   assign dec_valid = dvalid_q;
   assign dec_mode = mode_q;
   assign dec_src_stream = stream_q;
   assign dec_src_channel = chan_q;
   assign dec_variable_delay = vdel_q;
   assign dec_convert = conv_q;
   assign dec_input_law = in_law_q;
   assign dec_output_law = out_law_q;
   assign dec_vd_class = vd_q;
   assign dec_message_byte = message_q;
   assign dec_reserved_code = res_q;
endmodule

//--- tcw_host_model.sv
`timescale 1ns/1ps
module tcw_host_model (
   // clock
   input wire logic core_clk,
   // host port
   output logic host_wr,
   output logic host_rd,
   output logic [13:0] host_addr,
   output logic [15:0] host_wdata,
   output logic [1:0] word_select,
   input wire logic [15:0] host_rdata,
   input wire logic host_rd_valid
);
   logic var_en = 1'b1; // variable delay enabled up front
   // idle bus at start
   initial {host_wr, host_rd, host_addr, host_wdata, word_select} = '0;
   // one strobe cycle, changed on falling edges only
   task automatic wr(input logic sp, input logic [12:0] i, input logic [1:0] s, inout logic [15:0] d);
      if (s == tcw_pkg::SEL_LOW && d[0]) d[14:11] = 4'h0;
      if (!var_en) d[14] = 1'b0;
      @(negedge core_clk);
      {host_addr, word_select, host_wdata, host_wr} = {sp, i, s, d, 1'b1};
      @(negedge core_clk);
      host_wr = 1'b0;
      host_wdata = ~host_wdata; // released data never shows a stale word
   endtask
   // high word first, so translation starts on valid settings
   task automatic conn(input logic [12:0] i, input logic [4:0] h, inout logic [15:0] lo);
      logic [15:0] d;
      d = {11'h000, h};
      wr(1'b1, i, tcw_pkg::SEL_HIGH, d);
      wr(1'b1, i, tcw_pkg::SEL_LOW, lo);
   endtask
   // read strobe, answer taken at the next falling edge, one cycle later
   task automatic rd(input logic [12:0] i, input logic [1:0] s, output logic [15:0] q, output logic v);
      @(negedge core_clk);
      {host_addr, word_select, host_rd} = {1'b1, i, s, 1'b1};
      @(negedge core_clk);
      host_rd = 1'b0;
      {q, v} = {host_rdata, host_rd_valid};
   endtask
endmodule

//--- tcw_connection_decode_asserts.sv
`timescale 1ns/1ps
module tcw_connection_decode_asserts (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // requests
   input wire logic host_rd,
   input wire logic host_rd_valid,
   input wire logic fetch,
   // decoded settings
   input wire logic dec_valid,
   input wire tcw_pkg::tcw_mode_t dec_mode,
   input wire logic dec_variable_delay,
   input wire logic dec_convert,
   input wire logic [1:0] dec_input_law,
   input wire logic [1:0] dec_output_law,
   input wire logic [7:0] dec_message_byte,
   input wire logic dec_reserved_code
);
   // ----
   // fetch pipeline and host read answer
   // ----
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence fetch_taken; fetch; endsequence
   sequence answer_two; ##2 dec_valid; endsequence
   AST_FETCH_ANSWER: assert property (fetch_taken |-> answer_two)
      else $error("no decode two cycles after fetch");
   AST_NO_STRAY: assert property (dec_valid |-> $past(fetch, 2))
      else $error("decode without fetch");
   AST_RD_ANSWER: assert property (host_rd |=> host_rd_valid)
      else $error("read not answered");
   AST_MODE_HOLD: assert property (!dec_valid |-> $stable(dec_mode))
      else $error("mode moved between fetches");
   AST_ONE_MODE: assert property (dec_valid |-> $onehot(dec_mode))
      else $error("mode not one-hot");
   AST_SPECIAL_CONST: assert property (dec_valid && dec_mode != tcw_pkg::TCW_SWITCH |-> !dec_variable_delay)
      else $error("variable delay in special mode");
   AST_MSG_ONLY: assert property (dec_valid && dec_mode != tcw_pkg::TCW_MESSAGE |-> dec_message_byte == 8'h00)
      else $error("message byte outside message mode");
   AST_RESERVED_TRI: assert property (dec_reserved_code |-> dec_mode == tcw_pkg::TCW_TRISTATE)
      else $error("reserved code not tristate");
   AST_CONV_LAWS: assert property (dec_valid && dec_convert |-> dec_input_law != dec_output_law)
      else $error("translation with equal laws");
   AST_CONV_MODE: assert property (dec_convert |-> dec_mode inside {tcw_pkg::TCW_SWITCH, tcw_pkg::TCW_MESSAGE})
      else $error("translation in tristate or test mode");
endmodule
bind tcw_connection_decode tcw_connection_decode_asserts tcw_connection_decode_asserts_i (.core_clk, .rstn,
   .host_rd, .host_rd_valid, .fetch, .dec_valid, .dec_mode, .dec_variable_delay, .dec_convert, .dec_input_law,
   .dec_output_law, .dec_message_byte, .dec_reserved_code);

//--- tcw_connection_decode_bench.sv
`timescale 1ns/1ps
module tcw_connection_decode_bench;
   logic core_clk, rstn, host_wr, host_rd, host_rd_valid, fetch, v, dec_valid, dec_variable_delay;
   logic dec_convert, dec_vd_class, dec_reserved_code;
   logic [13:0] host_addr;
   logic [15:0] host_wdata, host_rdata, lo, q;
   logic [1:0] word_select, dec_input_law, dec_output_law;
   logic [4:0] out_stream, dec_src_stream;
   logic [7:0] out_channel, dec_src_channel, dec_message_byte;
   tcw_pkg::tcw_mode_t dec_mode;
   int n_errors = 0;
   int check_count = 0;
   tcw_connection_decode tcw_connection_decode_i (.core_clk, .rstn, .host_wr, .host_rd, .host_addr, .host_wdata,
      .word_select, .host_rdata, .host_rd_valid, .fetch, .out_stream, .out_channel, .dec_valid, .dec_mode,
      .dec_src_stream, .dec_src_channel, .dec_variable_delay, .dec_convert, .dec_input_law, .dec_output_law,
      .dec_vd_class, .dec_message_byte, .dec_reserved_code);
   tcw_host_model tcw_host_model_i (.core_clk, .host_wr, .host_rd, .host_addr, .host_wdata, .word_select,
      .host_rdata, .host_rd_valid);
   // ----
   // reference decode, packed like the outputs
   // ----
   function automatic logic [32:0] model(int l, int h);
      int c, m;
      c = (l >> 1) & 3;
      m = (l & 1) == 0 ? 1 : c == 1 ? 4 : c == 2 ? 8 : 2;
      return {m[3:0], l[13:1], (l & 1) == 0 && l[14], l[15] && h[3:2] != h[1:0] && (m == 1 || m == 4),
         h[3:0], h[4], m == 4 ? l[10:3] : 8'h00, (l & 1) == 1 && c == 3};
   endfunction
   task chk(input logic [32:0] got, input logic [32:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // free-running clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // random words: all modes, codes and laws get hit
   initial begin
      int k, s, t, i, l, h, r, e;
      {rstn, fetch, out_stream, out_channel} = '0;
      void'($urandom(32'h4a85));
      repeat (16) @(negedge core_clk);
      rstn = 1'b1;
      for (k = 0; k < 80; k++) begin
         i = $urandom_range(8191);
         h = $urandom_range(31);
         r = $urandom_range(3);
         lo = 16'($urandom());
         tcw_host_model_i.conn(i[12:0], h[4:0], lo);
         l = lo;
         q = ~lo;
         // refused writes: space line low, or select 11
         if (r < 2) tcw_host_model_i.wr(r[0], i[12:0], {r[0], 1'b1}, q);
         for (s = 0; s < 4; s++) begin
            tcw_host_model_i.rd(i[12:0], s[1:0], q, v);
            e = s == 1 ? l : s == 2 ? h : 0;
            chk({16'h0000, v, q}, {16'h0000, 1'b1, e[15:0]});
         end
         @(negedge core_clk);
         {fetch, out_stream, out_channel} = {1'b1, i[12:0]};
         @(negedge core_clk);
         fetch = 1'b0;
         for (t = 0; t < 8 && dec_valid !== 1'b1; t++) @(negedge core_clk);
         // a lost answer counts as an error, the stale outputs are still checked, and the loop ends; the verdict follows below
         if (t == 8) begin
            n_errors++;
            k = 80;
         end
         chk({dec_mode, dec_src_stream, dec_src_channel, dec_variable_delay, dec_convert, dec_input_law,
            dec_output_law, dec_vd_class, dec_message_byte, dec_reserved_code}, model(l, h));
      end
      end_of_test();
   end
endmodule
